/* File: dps_host_model.sv */
// partner model: host driving the enable pin, plus the analog pll side
// assumes the core_clk domain; lock follows output enable after a delay
`timescale 1ns/1ps
module dps_host_model (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       hostEnable,
   input  wire logic       slow,
   input  wire logic [1:0] pllOutEn,
   output logic            deviceEnableNPin,
   output logic [1:0]      pllLockDet,
   output logic [1:0]      pfdTick
);
   logic [4:0] lockCnt_r [2];
   logic [1:0] pfdCnt_r;
   ////////////////////////////////////////////////////////////////////////////
   // host drives enable
   always_ff @(posedge core_clk) deviceEnableNPin <= reset ? 1'b0 : hostEnable;
   // phase detector pulse every fourth cycle
   always_ff @(posedge core_clk) begin
      pfdCnt_r <= reset ? 2'h0 : pfdCnt_r + 2'h1;
      pfdTick  <= {2{pfdCnt_r == 2'h3}};
   end
   // lock comes promptly or slowly after outputs turn on
   for (genvar i = 0; i < 2; i++) begin : g_lock
      always_ff @(posedge core_clk) begin
         if (reset || !pllOutEn[i]) lockCnt_r[i] <= 5'h0;
         else if (lockCnt_r[i] != 5'h1f) lockCnt_r[i] <= lockCnt_r[i] + 5'h1;
      end
      assign pllLockDet[i] = lockCnt_r[i] >= (slow ? 5'h14 : 5'h02);
   end
endmodule : dps_host_model

/* File: dps_pkg.sv */
// dual pll power-up sequencer: shared types, register map and timing constants
// assumes a single 25 MHz core clock and a 10 MHz internal oscillator rate
package dps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // state encodings
   typedef enum logic [2:0] {
      MS_POR = 3'h1,
      MS_XO  = 3'h2,
      MS_RUN = 3'h4
   } dps_main_t;

   typedef enum logic [4:0] {
      PS_IDLE = 5'h01,
      PS_CAL  = 5'h02,
      PS_VCO  = 5'h04,
      PS_LOCK = 5'h08,
      PS_DONE = 5'h10
   } dps_pll_t;

   ////////////////////////////////////////////////////////////////////////////
   // configuration carriers, loaded from the strap pins at power-on reset
   typedef struct packed {
      logic [1:0] calSel;
      logic [1:0] vcoSel;
   } dps_pllcfg_t;

   typedef struct packed {
      logic        pll2StartSel;
      logic        xtalInUse;
      logic        statusASel;
      logic        statusBSel;
      dps_pllcfg_t pll1;
      dps_pllcfg_t pll2;
   } dps_strap_t;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses) and field positions
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_PLL1   = 4'h4;
   localparam logic [3:0] REG_PLL2   = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CTRL_P2SEL_BIT   = 0;
   localparam int CTRL_XTAL_BIT    = 1;
   localparam int CTRL_STA_BIT     = 2;
   localparam int CTRL_STB_BIT     = 3;
   localparam int CTRL_SOFTRST_BIT = 7;
   localparam int CFG_VCO_LSB      = 0;
   localparam int CFG_CAL_LSB      = 2;
   localparam int STAT_OUTEN_LSB   = 0;
   localparam int STAT_LOL_LSB     = 2;
   localparam int STAT_MAIN_LSB    = 4;
   localparam int STAT_PLL1_LSB    = 7;
   localparam int STAT_PLL2_LSB    = 12;

   ////////////////////////////////////////////////////////////////////////////
   // timing: oscillator rate against core rate, phase times in microseconds
   localparam int CORE_MHZ   = 25;
   localparam int OSC_MHZ    = 10;
   localparam int ACC_W      = 5;
   localparam int CNT_W      = 22;
   localparam int CAL_T0_US  = 30;
   localparam int CAL_T1_US  = 300;
   localparam int CAL_T2_US  = 3000;
   localparam int CAL_T3_US  = 300000;
   localparam int VCO_T0_US  = 20;
   localparam int VCO_T1_US  = 400;
   localparam int VCO_T2_US  = 4000;
   localparam int VCO_T3_US  = 200000;

endpackage : dps_pkg

/* File: dps_sequencer.sv */
// dual pll power-up sequencer with avalon-mm register slave
// assumes all inputs synchronous to core_clk; lock and pfd inputs come
// from the analog pll macros, pfd ticks are one-cycle pulses
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps

// Function
// - hold reset while either supply is low
// - release also needs enable pin high
// - after release start counters, then calibrate
// - wait for crystal amplitude before lock sequence
// - calibration lasts programmed oscillator tick count
// - vco wait lasts programmed oscillator tick count
// - outputs enable right after vco wait completes
// - loss-of-lock drops on the first pfd tick after lock
// - select clear: pll2 after pll1 finishes
// - select set: pll2 right after crystal phase
// - enable pin low powers whole device down
// - enable rise reloads registers from straps
// - register bus ignores traffic while enable low
// - soft reset bit reruns power-on reset
// - two-bit calibration field per pll
module dps_sequencer #(
   parameter logic [3:0][dps_pkg::CNT_W-1:0] CAL_TICKS = {
      dps_pkg::CNT_W'(dps_pkg::CAL_T3_US * dps_pkg::OSC_MHZ),
      dps_pkg::CNT_W'(dps_pkg::CAL_T2_US * dps_pkg::OSC_MHZ),
      dps_pkg::CNT_W'(dps_pkg::CAL_T1_US * dps_pkg::OSC_MHZ),
      dps_pkg::CNT_W'(dps_pkg::CAL_T0_US * dps_pkg::OSC_MHZ)},
   parameter logic [3:0][dps_pkg::CNT_W-1:0] VCO_TICKS = {
      dps_pkg::CNT_W'(dps_pkg::VCO_T3_US * dps_pkg::OSC_MHZ),
      dps_pkg::CNT_W'(dps_pkg::VCO_T2_US * dps_pkg::OSC_MHZ),
      dps_pkg::CNT_W'(dps_pkg::VCO_T1_US * dps_pkg::OSC_MHZ),
      dps_pkg::CNT_W'(dps_pkg::VCO_T0_US * dps_pkg::OSC_MHZ)}
) (
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic               deviceEnableNPin,
   input  wire logic               coreSupplyGood,
   input  wire logic               outputBank0SupplyGood,
   input  wire logic               crystalAmpOk,
   input  wire dps_pkg::dps_strap_t strapPins,
   input  wire logic [1:0]         pllLockDet,
   input  wire logic [1:0]         pfdTick,
   input  wire logic [3:0]         avsAddress,
   input  wire logic               avsRead,
   input  wire logic               avsWrite,
   input  wire logic [31:0]        avsWriteData,
   output logic [31:0]             avsReadData,
   output logic                    avsWaitrequest,
   output logic [1:0]              pllOutEn,
   output logic                    statusPinA,
   output logic                    statusPinB,
   output logic                    porActive
);

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   dps_pkg::dps_main_t   mainSt_r, mainSt_nxt;
   dps_pkg::dps_strap_t  cfg_r, cfg_nxt;
   dps_pkg::dps_pll_t    pllSt_r [2];
   dps_pkg::dps_pllcfg_t pllCfg [2];
   logic [dps_pkg::CNT_W-1:0] cnt_r [2];
   logic [1:0]  outEn_r, lol_r, pllGo;
   logic [dps_pkg::ACC_W-1:0] acc_r, acc_nxt, accSum;
   logic        tick_r, tick_nxt;
   logic        softRst_r, softRst_nxt;
   logic        porHold, busReq, busTake, wrOk;
   logic        waitReq_r, waitReq_nxt;
   logic [31:0] rdData_r, rdData_nxt, rdMux;
   logic        staA_r, staA_nxt, staB_r, staB_nxt, por_r, por_nxt;

   assign pllCfg[0] = cfg_r.pll1;
   assign pllCfg[1] = cfg_r.pll2;

   ////////////////////////////////////////////////////////////////////////////
   // power-on reset hold and top phase machine
   always_comb begin
      porHold = !coreSupplyGood || !outputBank0SupplyGood || !deviceEnableNPin || softRst_r;
      mainSt_nxt = mainSt_r;
      case (mainSt_r)
         dps_pkg::MS_POR: begin
            if (!porHold) mainSt_nxt = dps_pkg::MS_XO;
         end
         dps_pkg::MS_XO: begin
            if (!cfg_r.xtalInUse || crystalAmpOk) mainSt_nxt = dps_pkg::MS_RUN;
         end
         dps_pkg::MS_RUN: mainSt_nxt = dps_pkg::MS_RUN;
         default:         mainSt_nxt = dps_pkg::MS_POR;
      endcase
      if (porHold) mainSt_nxt = dps_pkg::MS_POR;
   end

   always_ff @(posedge core_clk) begin
      if (reset) mainSt_r <= dps_pkg::MS_POR;
      else       mainSt_r <= mainSt_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal oscillator rate: 10 of every 25 core cycles carry a tick
   always_comb begin
      accSum   = acc_r + dps_pkg::ACC_W'(dps_pkg::OSC_MHZ);
      acc_nxt  = accSum;
      tick_nxt = 1'b0;
      if (accSum >= dps_pkg::ACC_W'(dps_pkg::CORE_MHZ)) begin
         acc_nxt  = accSum - dps_pkg::ACC_W'(dps_pkg::CORE_MHZ);
         tick_nxt = 1'b1;
      end
      if (mainSt_r == dps_pkg::MS_POR) begin
         acc_nxt  = '0;
         tick_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         acc_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         acc_r  <= acc_nxt;
         tick_r <= tick_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-pll calibration, vco wait, output enable and lock tracking
   // pll2 starts serially after pll1 done, in parallel when pll2StartSel is set
   assign pllGo[0] = (mainSt_r == dps_pkg::MS_RUN);
   assign pllGo[1] = cfg_r.pll2StartSel ? (mainSt_r == dps_pkg::MS_RUN)
                                        : (pllSt_r[0] == dps_pkg::PS_DONE);

   for (genvar i = 0; i < 2; i++) begin : g_pll
      dps_pkg::dps_pll_t         st_nxt;
      logic [dps_pkg::CNT_W-1:0] cnt_nxt;
      logic                      en_nxt, lol_nxt;

      always_comb begin
         st_nxt  = pllSt_r[i];
         cnt_nxt = cnt_r[i];
         en_nxt  = outEn_r[i];
         lol_nxt = lol_r[i];
         case (pllSt_r[i])
            dps_pkg::PS_IDLE: begin
               if (pllGo[i]) st_nxt = dps_pkg::PS_CAL;
            end
            dps_pkg::PS_CAL: begin
               if (tick_r) begin
                  if (cnt_r[i] == CAL_TICKS[pllCfg[i].calSel] - 1'b1) begin
                     st_nxt  = dps_pkg::PS_VCO;
                     cnt_nxt = '0;
                  end else cnt_nxt = cnt_r[i] + 1'b1;
               end
            end
            dps_pkg::PS_VCO: begin
               if (tick_r) begin
                  if (cnt_r[i] == VCO_TICKS[pllCfg[i].vcoSel] - 1'b1) begin
                     st_nxt  = dps_pkg::PS_LOCK;
                     cnt_nxt = '0;
                     en_nxt  = 1'b1;
                  end else cnt_nxt = cnt_r[i] + 1'b1;
               end
            end
            // clear on pfd edge once locked
            dps_pkg::PS_LOCK: begin
               if (pllLockDet[i] && pfdTick[i]) begin
                  st_nxt  = dps_pkg::PS_DONE;
                  lol_nxt = 1'b0;
               end
            end
            dps_pkg::PS_DONE: st_nxt = dps_pkg::PS_DONE;
            default:          st_nxt = dps_pkg::PS_IDLE;
         endcase
         if (porHold || mainSt_r == dps_pkg::MS_POR) begin
            st_nxt  = dps_pkg::PS_IDLE;
            cnt_nxt = '0;
            en_nxt  = 1'b0;
            lol_nxt = 1'b1;
         end
      end

      always_ff @(posedge core_clk) begin
         if (reset) begin
            pllSt_r[i] <= dps_pkg::PS_IDLE;
            cnt_r[i]   <= '0;
            outEn_r[i] <= 1'b0;
            lol_r[i]   <= 1'b1;
         end else begin
            pllSt_r[i] <= st_nxt;
            cnt_r[i]   <= cnt_nxt;
            outEn_r[i] <= en_nxt;
            lol_r[i]   <= lol_nxt;
         end
      end

      // cal moves to vco only on a tick at the terminal count; vco terminal tick moves to lock
      calEnd_a: assert property ($past(pllSt_r[i]) == dps_pkg::PS_CAL
         && pllSt_r[i] == dps_pkg::PS_VCO |-> $past(tick_r)
         && $past(cnt_r[i]) == CAL_TICKS[$past(pllCfg[i].calSel)] - 1'b1)
         else $error("calibration ended off terminal count");
      vcoEnd_a: assert property (pllSt_r[i] == dps_pkg::PS_VCO && tick_r && !porHold
         && cnt_r[i] == VCO_TICKS[pllCfg[i].vcoSel] - 1'b1
         |=> pllSt_r[i] == dps_pkg::PS_LOCK && outEn_r[i])
         else $error("vco wait end did not enable outputs");
      outOn_a: assert property ($rose(outEn_r[i]) |-> $past(pllSt_r[i]) == dps_pkg::PS_VCO)
         else $error("outputs enabled outside vco wait end");
      lolFall_a: assert property ($fell(lol_r[i])
         |-> $past(pllLockDet[i]) && $past(pfdTick[i]) && pllSt_r[i] == dps_pkg::PS_DONE)
         else $error("loss of lock cleared without pfd lock edge");
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon-mm slave: one wait state, then readdata with waitrequest low
   assign busReq  = avsRead || avsWrite;
   assign busTake = busReq && !waitReq_r;
   assign wrOk    = avsWrite && busTake && deviceEnableNPin && mainSt_r != dps_pkg::MS_POR;

   always_comb begin
      rdMux = '0;
      case (avsAddress)
         dps_pkg::REG_CTRL: begin
            rdMux[dps_pkg::CTRL_P2SEL_BIT] = cfg_r.pll2StartSel;
            rdMux[dps_pkg::CTRL_XTAL_BIT]  = cfg_r.xtalInUse;
            rdMux[dps_pkg::CTRL_STA_BIT]   = cfg_r.statusASel;
            rdMux[dps_pkg::CTRL_STB_BIT]   = cfg_r.statusBSel;
         end
         dps_pkg::REG_PLL1:   rdMux[3:0] = cfg_r.pll1;
         dps_pkg::REG_PLL2:   rdMux[3:0] = cfg_r.pll2;
         dps_pkg::REG_STATUS: begin
            rdMux[dps_pkg::STAT_OUTEN_LSB +: 2] = outEn_r;
            rdMux[dps_pkg::STAT_LOL_LSB +: 2]   = lol_r;
            rdMux[dps_pkg::STAT_MAIN_LSB +: 3]  = mainSt_r;
            rdMux[dps_pkg::STAT_PLL1_LSB +: 5]  = pllSt_r[0];
            rdMux[dps_pkg::STAT_PLL2_LSB +: 5]  = pllSt_r[1];
         end
         default: rdMux = '0;
      endcase
      if (!deviceEnableNPin) rdMux = '0;
      waitReq_nxt = !(busReq && waitReq_r);
      rdData_nxt  = (avsRead && waitReq_r) ? rdMux : rdData_r;
   end

   // configuration registers, strap reload and soft reset pulse
   always_comb begin
      cfg_nxt     = cfg_r;
      softRst_nxt = 1'b0;
      if (mainSt_r == dps_pkg::MS_POR) cfg_nxt = strapPins;
      else if (wrOk) begin
         case (avsAddress)
            dps_pkg::REG_CTRL: begin
               cfg_nxt.pll2StartSel = avsWriteData[dps_pkg::CTRL_P2SEL_BIT];
               cfg_nxt.xtalInUse    = avsWriteData[dps_pkg::CTRL_XTAL_BIT];
               cfg_nxt.statusASel   = avsWriteData[dps_pkg::CTRL_STA_BIT];
               cfg_nxt.statusBSel   = avsWriteData[dps_pkg::CTRL_STB_BIT];
               softRst_nxt          = avsWriteData[dps_pkg::CTRL_SOFTRST_BIT];
            end
            dps_pkg::REG_PLL1: cfg_nxt.pll1 = avsWriteData[3:0];
            dps_pkg::REG_PLL2: cfg_nxt.pll2 = avsWriteData[3:0];
            default:           cfg_nxt      = cfg_r;
         endcase
      end
      // status pin routing of the loss-of-lock flags
      staA_nxt = cfg_r.statusASel ? lol_r[1] : lol_r[0];
      staB_nxt = cfg_r.statusBSel ? lol_r[1] : lol_r[0];
      por_nxt  = (mainSt_nxt == dps_pkg::MS_POR);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cfg_r     <= '0;
         softRst_r <= 1'b0;
         waitReq_r <= 1'b1;
         rdData_r  <= '0;
         staA_r    <= 1'b1;
         staB_r    <= 1'b1;
         por_r     <= 1'b1;
      end else begin
         cfg_r     <= cfg_nxt;
         softRst_r <= softRst_nxt;
         waitReq_r <= waitReq_nxt;
         rdData_r  <= rdData_nxt;
         staA_r    <= staA_nxt;
         staB_r    <= staB_nxt;
         por_r     <= por_nxt;
      end
   end

   assign avsReadData    = rdData_r;
   assign avsWaitrequest = waitReq_r;
   assign pllOutEn       = outEn_r;
   assign statusPinA     = staA_r;
   assign statusPinB     = staB_r;
   assign porActive      = por_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence softWrite_s;
      avsWrite && !waitReq_r && avsAddress == dps_pkg::REG_CTRL
         && avsWriteData[dps_pkg::CTRL_SOFTRST_BIT] && deviceEnableNPin
         && mainSt_r != dps_pkg::MS_POR;
   endsequence
   sequence rerun_s;
      softRst_r ##1 (mainSt_r == dps_pkg::MS_POR && pllOutEn == 2'b00);
   endsequence

   supplyHold_a: assert property (!coreSupplyGood || !outputBank0SupplyGood
      |=> mainSt_r == dps_pkg::MS_POR)
      else $error("left reset with a supply low");
   enableHold_a: assert property (!deviceEnableNPin
      |=> mainSt_r == dps_pkg::MS_POR ##1 pllOutEn == 2'b00)
      else $error("enable low did not hold reset");
   porExit_a: assert property (mainSt_r == dps_pkg::MS_POR && !porHold
      |=> mainSt_r == dps_pkg::MS_XO && pllSt_r[0] == dps_pkg::PS_IDLE && cnt_r[0] == '0)
      else $error("reset release did not start sequence");
   xtalWait_a: assert property (mainSt_r == dps_pkg::MS_XO && cfg_r.xtalInUse
      && !crystalAmpOk |=> pllSt_r[0] == dps_pkg::PS_IDLE && pllSt_r[1] == dps_pkg::PS_IDLE)
      else $error("pll started before crystal swing");
   serialStart_a: assert property ($rose(pllSt_r[1] == dps_pkg::PS_CAL)
      && !$past(cfg_r.pll2StartSel) |-> $past(pllSt_r[0]) == dps_pkg::PS_DONE)
      else $error("pll2 started before pll1 finished");
   parStart_a: assert property (cfg_r.pll2StartSel && !porHold
      && mainSt_r == dps_pkg::MS_RUN && pllSt_r[1] == dps_pkg::PS_IDLE
      |=> pllSt_r[1] == dps_pkg::PS_CAL)
      else $error("pll2 did not start in parallel");
   strapLoad_a: assert property (mainSt_r == dps_pkg::MS_POR
      |=> cfg_r == $past(strapPins))
      else $error("straps not loaded in reset");
   busQuiet_a: assert property (avsRead && waitReq_r && !deviceEnableNPin
      |=> !avsWaitrequest && avsReadData == 32'h0000_0000)
      else $error("bus answered data while disabled");
   softReset_a: assert property (softWrite_s |=> rerun_s)
      else $error("soft reset did not rerun reset");
   abortAll_a: assert property ($rose(porHold) && mainSt_r == dps_pkg::MS_RUN
      |=> pllSt_r[0] == dps_pkg::PS_IDLE && pllSt_r[1] == dps_pkg::PS_IDLE
      && lol_r == 2'b11 && outEn_r == 2'b00)
      else $error("abort did not clear sequencer");

endmodule : dps_sequencer

/* File: tb_top.sv */
// testbench: power-up sequencing, aborts, soft reset and register bus
// assumes shortened phase counts; expectations from tick counts times 2.5
`timescale 1ns/1ps
module tb_top;
   localparam int CT [4] = '{2, 4, 6, 8};
   localparam int VT [4] = '{2, 4, 6, 8};
   logic               core_clk;
   logic               reset;
   logic               hostEn, slow, coreOk, bankOk, ampOk, enPin;
   dps_pkg::dps_strap_t strap;
   logic [1:0]         lockDet, pfd, pllOutEn;
   logic [3:0]         avsAddress;
   logic               avsRead, avsWrite, avsWaitrequest;
   logic [31:0]        avsWriteData, avsReadData;
   logic               statusPinA, statusPinB, porActive;
   int                 n_mismatch = 0;
   int                 cmp_count = 0;
   logic [31:0]        rs = 32'h2b;

   dps_sequencer #(
      .CAL_TICKS({22'h8, 22'h6, 22'h4, 22'h2}),
      .VCO_TICKS({22'h8, 22'h6, 22'h4, 22'h2})
   ) dps_sequencer_i (
      .core_clk(core_clk), .reset(reset), .deviceEnableNPin(enPin),
      .coreSupplyGood(coreOk), .outputBank0SupplyGood(bankOk),
      .crystalAmpOk(ampOk), .strapPins(strap), .pllLockDet(lockDet),
      .pfdTick(pfd), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
      .pllOutEn(pllOutEn), .statusPinA(statusPinA),
      .statusPinB(statusPinB), .porActive(porActive));

   dps_host_model dps_host_model_i (
      .core_clk(core_clk), .reset(reset), .hostEnable(hostEn), .slow(slow),
      .pllOutEn(pllOutEn), .deviceEnableNPin(enPin), .pllLockDet(lockDet),
      .pfdTick(pfd));

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : rnd

   // cycles from crystal good to output enable
   function automatic int onTime(input int c, input int v);
      return 3 + (CT[c] + VT[v]) * 5 / 2;
   endfunction : onTime

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic chkNear(input int t, input int e);
      chk(32'((t > e - 6 && t < e + 6) ? e : t), 32'(e));
   endtask : chkNear

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // one avalon-mm transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avsAddress   <= a;
      avsWriteData <= d;
      avsRead      <= !wr;
      avsWrite     <= wr;
      do begin
         @(posedge core_clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 50);
      if (n >= 50) n_mismatch++;
      q = avsReadData;
      avsRead  <= 1'b0;
      avsWrite <= 1'b0;
   endtask : bus

   task automatic finish_test;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      int t1, t2, tl, c1, v1, c2, v2, dly;
      logic lk;
      logic [31:0] q;
      reset = 1'b1; hostEn = 1'b0; slow = 1'b0; coreOk = 1'b1; bankOk = 1'b1;
      ampOk = 1'b0; strap = '0; avsAddress = 4'h0; avsRead = 1'b0;
      avsWrite = 1'b0; avsWriteData = 32'h0;
      cyc(2);
      reset <= 1'b0;
      cyc(8);
      chk(porActive, 1);
      bus(1'b1, dps_pkg::REG_PLL1, 32'hf, q);
      bus(1'b0, dps_pkg::REG_PLL1, 32'h0, q);
      chk(q, 0);
      hostEn <= 1'b1;
      coreOk <= 1'b0;
      cyc(8);
      chk(porActive, 1);
      coreOk <= 1'b1;
      bankOk <= 1'b0;
      cyc(8);
      chk(porActive, 1);
      bankOk <= 1'b1;
      hostEn <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         c1 = k; v1 = int'(rnd() % 4); c2 = int'(rnd() % 4); v2 = int'(rnd() % 4);
         dly = k[0] ? 20 : 2;
         slow <= k[0];
         strap <= {k[1], 1'b1, 1'b0, 1'b1, 2'(c1), 2'(v1), 2'(c2), 2'(v2)};
         cyc(2);
         hostEn <= 1'b1;
         cyc(12);
         chk(porActive, 0);
         chk(pllOutEn, 0);
         bus(1'b0, dps_pkg::REG_STATUS, 32'h0, q);
         chk(q[6:4], 3'h2);
         bus(1'b0, dps_pkg::REG_PLL1, 32'h0, q);
         chk(q, 32'({2'(c1), 2'(v1)}));
         bus(1'b0, 4'h2, 32'h0, q);
         chk(q, 0);
         ampOk <= 1'b1;
         t1 = -1; t2 = -1; tl = -1; lk = 1'b1;
         for (int t = 0; t < 3000 && (t1 < 0 || t2 < 0 || tl < 0); t++) begin
            @(posedge core_clk);
            if (pllOutEn[0] === 1'b1 && t1 < 0) begin
               t1 = t;
               lk = lockDet[0];
            end
            if (statusPinA === 1'b0 && tl < 0) tl = t;
            if (pllOutEn[1] === 1'b1 && t2 < 0) t2 = t;
         end
         chkNear(t1, onTime(c1, v1));
         chk(lk, 0);
         chkNear(tl, t1 + dly + 3);
         chkNear(t2, k[1] ? onTime(c2, v2) : tl + onTime(c2, v2));
         cyc(30);
         chk(statusPinB, 0);
         case (k)
            1: coreOk <= 1'b0;
            3: bankOk <= 1'b0;
            default: hostEn <= 1'b0;
         endcase
         cyc(4);
         chk(pllOutEn, 0);
         chk(porActive, 1);
         coreOk <= 1'b1; bankOk <= 1'b1; hostEn <= 1'b0; ampOk <= 1'b0;
      end
      hostEn <= 1'b1;
      ampOk  <= 1'b1;
      cyc(150);
      bus(1'b1, dps_pkg::REG_PLL2, 32'hd, q);
      bus(1'b0, dps_pkg::REG_PLL2, 32'h0, q);
      chk(q, 32'hd);
      bus(1'b1, dps_pkg::REG_CTRL, 32'h80, q);
      lk = 1'b0;
      for (int t = 0; t < 6; t++) begin
         @(posedge core_clk);
         if (porActive === 1'b1) lk = 1'b1;
      end
      chk(lk, 1);
      chk(pllOutEn, 0);
      cyc(4);
      bus(1'b0, dps_pkg::REG_CTRL, 32'h0, q);
      chk(q, {28'h0, strap.statusBSel, strap.statusASel, strap.xtalInUse,
              strap.pll2StartSel});
      finish_test();
   end
endmodule : tb_top
